// ===== dct_pkg.sv
// constants shared by the dual carrier timer and demodulator block
package dct_pkg;
    // register indices, byte address is four times the index
    localparam logic [3:0] IDX_CTRL_A   = 4'h0; // timer_a_control
    localparam logic [3:0] IDX_CTRL_SH  = 4'h1; // shared_timer_control
    localparam logic [3:0] IDX_CTRL_B   = 4'h2; // timer_b_control
    localparam logic [3:0] IDX_RLD_AL   = 4'h3; // timer_a_low_phase_reload
    localparam logic [3:0] IDX_RLD_AH   = 4'h4; // timer_a_high_phase_reload
    localparam logic [3:0] IDX_RLD_BL   = 4'h5; // timer_b_reload_low_byte
    localparam logic [3:0] IDX_RLD_BH   = 4'h6; // timer_b_reload_high_byte
    localparam logic [3:0] IDX_CAP_AR   = 4'h7; // timer_a_rising_capture
    localparam logic [3:0] IDX_CAP_AF   = 4'h8; // timer_a_falling_capture
    localparam logic [3:0] IDX_CAP_BL   = 4'h9; // timer_b_capture_low_byte
    localparam logic [3:0] IDX_CAP_BH   = 4'ha; // timer_b_capture_high_byte
    // per-timer control fields
    localparam int BIT_EN      = 7;
    localparam int BIT_SINGLE  = 6; // timer_b: edge-ignore in demod
    localparam int BIT_TOUT    = 5;
    localparam int BIT_CLK_HI  = 4;
    localparam int BIT_CLK_LO  = 3;
    localparam int BIT_CAP_IE  = 2;
    localparam int BIT_TOUT_IE = 1;
    localparam int BIT_PIN_OUT = 0;
    // shared control fields
    localparam int BIT_MODE    = 7;
    localparam int BIT_PIN_SEL = 6;
    localparam int BIT_EDGE_HI = 5;
    localparam int BIT_EDGE_LO = 4;
    localparam int BIT_SUB_HI  = 3;
    localparam int BIT_SUB_LO  = 2;
    localparam int BIT_INIT_A  = 1; // rising flag in demod
    localparam int BIT_INIT_B  = 0; // falling flag in demod
    // encodings
    localparam logic [1:0] SUB_NORMAL = 2'h0;
    localparam logic [1:0] SUB_PPONG  = 2'h1;
    localparam logic [1:0] SUB_FORCE0 = 2'h2;
    localparam logic [1:0] SUB_FORCE1 = 2'h3;
    localparam logic [1:0] EDGE_FALL  = 2'h0;
    localparam logic [1:0] EDGE_RISE  = 2'h1;
    // reset values
    localparam logic [7:0]  RST_CTRL   = 8'h00;
    localparam logic [7:0]  RST_RELOAD = 8'hff;
    localparam logic [7:0]  ONE_A      = 8'h01;
    localparam logic [15:0] ONE_B      = 16'h0001;
endpackage : dct_pkg

// ===== dct_prescale.sv
// count-clock prescaler: tick every 1, 2, 4 or 8 system clocks
`timescale 1ns/1ps
module dct_prescale (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    // divider select and tick
    input  wire logic [1:0] div_sel_i,
    output logic            tick_o
);
    logic [2:0] cnt_q;
    logic [2:0] mask;

    // free-running divider, shared phase keeps ticks evenly spaced
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 3'h0;
        end else if (ce_i) begin
            cnt_q <= cnt_q + 3'h1;
        end
    end

    // divide by two to the power of the select code
    always_comb begin
        case (div_sel_i)
            2'h0:    mask = 3'h0;
            2'h1:    mask = 3'h1;
            2'h2:    mask = 3'h3;
            default: mask = 3'h7;
        endcase
    end
    assign tick_o = ce_i & ((cnt_q & mask) == mask);
endmodule : dct_prescale

// ===== dct_edge_sync.sv
// demodulator input: pin select, two-flop synchronisers, edge pulses
`timescale 1ns/1ps
module dct_edge_sync (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    // pins and select
    input  wire logic pin_a_i,
    input  wire logic pin_b_i,
    input  wire logic sel_b_i,
    // edge pulses
    output logic      rise_o,
    output logic      fall_o
);
    logic [1:0] meta_q;
    logic [1:0] sync_q;
    logic       prev_q;
    logic       cur;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= 2'h0;
            sync_q <= 2'h0;
            prev_q <= 1'b0;
        end else if (ce_i) begin
            meta_q <= {pin_b_i, pin_a_i};
            sync_q <= meta_q;
            prev_q <= cur;
        end
    end

    // pin chosen after synchronising, so switching cannot go metastable
    assign cur    = sel_b_i ? sync_q[1] : sync_q[0];
    assign rise_o = ce_i & cur & ~prev_q;
    assign fall_o = ce_i & ~cur & prev_q;
endmodule : dct_edge_sync

// ===== dct_timer.sv
// dual carrier timer / demodulator with classic wishbone registers
//
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module dct_timer
    import dct_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // demodulator pins
    input  wire logic        demod_input_pin_a_i,
    input  wire logic        demod_input_pin_b_i,
    // timer outputs and event pulses
    output logic             timer_a_output_o,
    output logic             timer_b_output_o,
    output logic             timer_a_event_o,
    output logic             timer_b_event_o
);
    import dct_pkg::*;

    logic [7:0]  ctl_a_q, ctl_b_q, ctl_sh_q;
    logic        en_a_q, en_b_q, tout_a_q, tout_b_q;
    logic [1:0]  eflag_q;
    logic [7:0]  rld_al_q, rld_ah_q, rld_bl_q, rld_bh_q;
    logic [7:0]  cap_ar_q, cap_af_q;
    logic [15:0] cap_b_q;
    logic [7:0]  cnt_a_q;
    logic [15:0] cnt_b_q;
    logic        lvl_a_q, lvl_b_q, out_b_q;
    logic        loaded_a_q, loaded_b_q, half_a_q, seen_b_q;
    logic        ack_q, irq_a_q, irq_b_q;
    logic [31:0] rdat_q;
    logic [7:0]  rd;
    logic        req, wr;
    logic [3:0]  idx;
    logic [7:0]  wd;
    logic        tick_a, tick_b, rise, fall, rise_ev, fall_ev, edge_any;
    logic        demod, pp, single_a, single_b, ign_b;
    logic        term_a, term_b, zero_a, zero_b;
    logic        cap_a, cap_b_edge, cap_b_tout, tset_a, tset_b;

    // shared mode and field decode
    assign demod    = ctl_sh_q[BIT_MODE];
    assign pp       = ~demod &
                      (ctl_sh_q[BIT_SUB_HI:BIT_SUB_LO] == SUB_PPONG);
    assign single_a = ctl_a_q[BIT_SINGLE];
    assign single_b = ctl_b_q[BIT_SINGLE];
    assign ign_b    = ctl_b_q[BIT_SINGLE];

    // count clocks, timer_a uses the same field layout as timer_b
    dct_prescale u_pre_a (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .div_sel_i (ctl_a_q[BIT_CLK_HI:BIT_CLK_LO]),
        .tick_o    (tick_a)
    );
    dct_prescale u_pre_b (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .div_sel_i (ctl_b_q[BIT_CLK_HI:BIT_CLK_LO]),
        .tick_o    (tick_b)
    );
    dct_edge_sync u_edge (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .pin_a_i (demod_input_pin_a_i),
        .pin_b_i (demod_input_pin_b_i),
        .sel_b_i (ctl_sh_q[BIT_PIN_SEL]),
        .rise_o  (rise),
        .fall_o  (fall)
    );

    // edge select: falling, rising, or both for the upper codes
    assign rise_ev  = rise & (ctl_sh_q[BIT_EDGE_HI:BIT_EDGE_LO] != EDGE_FALL);
    assign fall_ev  = fall & (ctl_sh_q[BIT_EDGE_HI:BIT_EDGE_LO] != EDGE_RISE);
    assign edge_any = demod & (rise_ev | fall_ev);

    // counter events; count one reaching zero is the only terminal count,
    // so a zero start wraps through all ones without a time-out
    assign term_a = en_a_q & loaded_a_q & ~demod & tick_a
                    & (cnt_a_q == ONE_A);
    assign term_b = en_b_q & loaded_b_q & ~demod & tick_b
                    & (cnt_b_q == ONE_B);
    assign cap_a  = en_a_q & loaded_a_q & edge_any;
    assign zero_a = en_a_q & loaded_a_q & demod & ~edge_any & tick_a
                    & (cnt_a_q == ONE_A);
    assign cap_b_edge = en_b_q & edge_any
                        & (~loaded_b_q | ~(ign_b & seen_b_q));
    assign cap_b_tout = en_b_q & loaded_b_q & ign_b & seen_b_q
                        & zero_a & ~edge_any;
    assign zero_b = en_b_q & loaded_b_q & demod & ~cap_b_edge & tick_b
                    & (cnt_b_q == ONE_B);
    // timer_a modulo-N flags only after the second phase of a cycle, timer_b on every terminal count
    assign tset_a = (term_a & (single_a | pp | half_a_q)) | zero_a;
    assign tset_b = term_b | zero_b;

    // bus decode: one access per request, answered one cycle later
    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr  = req & wb_we_i & wb_sel_i[0];
    assign idx = wb_adr_i[5:2];
    assign wd  = wb_dat_i[7:0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else if (ce_i) begin
            ack_q <= req;
        end
    end

    // plain control bits; flags and enables are kept apart
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_a_q  <= RST_CTRL;
            ctl_b_q  <= RST_CTRL;
            ctl_sh_q <= RST_CTRL;
        end else if (ce_i && wr) begin
            if (idx == IDX_CTRL_A) ctl_a_q <= wd;
            if (idx == IDX_CTRL_B) ctl_b_q <= wd;
            if (idx == IDX_CTRL_SH && !demod) ctl_sh_q <= wd;
            if (idx == IDX_CTRL_SH && demod) begin
                ctl_sh_q[7:2] <= wd[7:2];
            end
        end
    end

    // reload registers take effect only when the counter loads
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rld_al_q <= RST_RELOAD;
            rld_ah_q <= RST_RELOAD;
            rld_bl_q <= RST_RELOAD;
            rld_bh_q <= RST_RELOAD;
        end else if (ce_i && wr) begin
            if (idx == IDX_RLD_AL) rld_al_q <= wd;
            if (idx == IDX_RLD_AH) rld_ah_q <= wd;
            if (idx == IDX_RLD_BL) rld_bl_q <= wd;
            if (idx == IDX_RLD_BH) rld_bh_q <= wd;
        end
    end

    // enables: software write, then hardware stop and ping-pong handover
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_a_q <= 1'b0;
            en_b_q <= 1'b0;
        end else if (ce_i) begin
            if (wr && idx == IDX_CTRL_A) en_a_q <= wd[BIT_EN];
            if (wr && idx == IDX_CTRL_B) en_b_q <= wd[BIT_EN];
            if (term_a && (single_a || pp)) en_a_q <= 1'b0;
            if (term_b && (single_b || pp)) en_b_q <= 1'b0;
            if (term_a && pp) en_b_q <= 1'b1;
            if (term_b && pp) en_a_q <= 1'b1;
        end
    end

    // sticky flags: a write of one clears, a same-cycle set wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tout_a_q <= 1'b0;
            tout_b_q <= 1'b0;
            eflag_q  <= 2'h0;
        end else if (ce_i) begin
            if (wr && idx == IDX_CTRL_A && wd[BIT_TOUT]) begin
                tout_a_q <= 1'b0;
            end
            if (wr && idx == IDX_CTRL_B && wd[BIT_TOUT]) begin
                tout_b_q <= 1'b0;
            end
            if (wr && idx == IDX_CTRL_SH && demod) begin
                eflag_q <= eflag_q & ~wd[1:0];
            end
            if (tset_a) tout_a_q <= 1'b1;
            if (tset_b) tout_b_q <= 1'b1;
            if ((cap_a || cap_b_edge) && rise_ev) eflag_q[1] <= 1'b1;
            if ((cap_a || cap_b_edge) && fall_ev) eflag_q[0] <= 1'b1;
        end
    end

    // timer_a: load on enable (on the first edge in demod), count on ticks, capture in demod
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_a_q    <= RST_RELOAD;
            lvl_a_q    <= 1'b1;
            loaded_a_q <= 1'b0;
            half_a_q   <= 1'b0;
        end else if (ce_i) begin
            if (!en_a_q) begin
                loaded_a_q <= 1'b0;
                half_a_q   <= 1'b0;
                lvl_a_q    <= ~ctl_sh_q[BIT_INIT_A];
            end else if (!loaded_a_q) begin
                if (!demod) begin
                    loaded_a_q <= 1'b1;
                    lvl_a_q    <= ctl_sh_q[BIT_INIT_A];
                    cnt_a_q    <= ctl_sh_q[BIT_INIT_A] ? rld_ah_q
                                                       : rld_al_q;
                end else if (edge_any) begin
                    loaded_a_q <= 1'b1;
                    cnt_a_q    <= rld_al_q;
                end
            end else if (cap_a) begin
                cnt_a_q <= rld_al_q;
            end else if (term_a) begin
                lvl_a_q  <= ~lvl_a_q;
                half_a_q <= ~half_a_q;
                // new level low loads the low phase, high the high phase
                cnt_a_q  <= lvl_a_q ? rld_al_q : rld_ah_q;
            end else if (tick_a) begin
                cnt_a_q <= cnt_a_q - ONE_A;
            end
        end
    end

    // timer_a captures hold the complement of the running count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap_ar_q <= RST_CTRL;
            cap_af_q <= RST_CTRL;
        end else if (ce_i && cap_a) begin
            if (rise_ev) cap_ar_q <= ~cnt_a_q;
            if (fall_ev) cap_af_q <= ~cnt_a_q;
        end
    end

    // timer_b: sixteen-bit load, one-shot edge arming in demod
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_b_q    <= {RST_RELOAD, RST_RELOAD};
            lvl_b_q    <= 1'b1;
            loaded_b_q <= 1'b0;
        end else if (ce_i) begin
            if (!en_b_q) begin
                loaded_b_q <= 1'b0;
                lvl_b_q    <= ~ctl_sh_q[BIT_INIT_B];
            end else if (!demod && !loaded_b_q) begin
                loaded_b_q <= 1'b1;
                lvl_b_q    <= ctl_sh_q[BIT_INIT_B];
                cnt_b_q    <= {rld_bh_q, rld_bl_q};
            end else if (cap_b_edge) begin
                loaded_b_q <= 1'b1;
                cnt_b_q    <= {rld_bh_q, rld_bl_q};
            end else if (term_b) begin
                lvl_b_q <= ~lvl_b_q;
                cnt_b_q <= {rld_bh_q, rld_bl_q};
            end else if (loaded_b_q && tick_b) begin
                cnt_b_q <= cnt_b_q - ONE_B;
            end
        end
    end

    // arming: clearing the ignore bit re-arms the next edge capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seen_b_q <= 1'b0;
        end else if (ce_i) begin
            if (!ign_b) begin
                seen_b_q <= 1'b0;
            end else if (cap_b_edge) begin
                seen_b_q <= 1'b1;
            end
        end
    end

    // timer_b capture, no reload on the timer_a time-out path
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap_b_q <= {RST_CTRL, RST_CTRL};
        end else if (ce_i && (cap_b_edge || cap_b_tout)) begin
            cap_b_q <= ~cnt_b_q;
        end
    end

    // timer_b output level; submode force wins whether enabled or not
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_b_q <= 1'b1;
        end else if (ce_i) begin
            if (!demod && ctl_sh_q[BIT_SUB_HI:BIT_SUB_LO] == SUB_FORCE0) begin
                out_b_q <= 1'b0;
            end else if (!demod &&
                         ctl_sh_q[BIT_SUB_HI:BIT_SUB_LO] == SUB_FORCE1) begin
                out_b_q <= 1'b1;
            end else begin
                out_b_q <= lvl_b_q;
            end
        end
    end

    // event pulses gated by the per-timer masks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_a_q <= 1'b0;
            irq_b_q <= 1'b0;
        end else if (ce_i) begin
            irq_a_q <= (tset_a & ctl_a_q[BIT_TOUT_IE])
                     | (cap_a & ctl_a_q[BIT_CAP_IE]);
            irq_b_q <= (tset_b & ctl_b_q[BIT_TOUT_IE])
                     | ((cap_b_edge | cap_b_tout)
                        & ctl_b_q[BIT_CAP_IE]);
        end
    end

    // read mux; edge flags replace the initial levels in demod
    always_comb begin
        case (idx)
            IDX_CTRL_A: rd = {en_a_q, ctl_a_q[6], tout_a_q, ctl_a_q[4:0]};
            IDX_CTRL_B: rd = {en_b_q, ctl_b_q[6], tout_b_q, ctl_b_q[4:0]};
            IDX_CTRL_SH: rd = demod ? {ctl_sh_q[7:2], eflag_q} : ctl_sh_q;
            IDX_RLD_AL: rd = rld_al_q;
            IDX_RLD_AH: rd = rld_ah_q;
            IDX_RLD_BL: rd = rld_bl_q;
            IDX_RLD_BH: rd = rld_bh_q;
            IDX_CAP_AR: rd = cap_ar_q;
            IDX_CAP_AF: rd = cap_af_q;
            IDX_CAP_BL: rd = cap_b_q[7:0];
            IDX_CAP_BH: rd = cap_b_q[15:8];
            default:    rd = 8'h00; // unmapped reads zero, still acked
        endcase
    end

    // read data is latched with the answer and held afterwards
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= 32'h0;
        end else if (ce_i && req && !wb_we_i) begin
            rdat_q <= {24'h0, rd};
        end
    end

    assign wb_dat_o         = rdat_q;
    assign wb_ack_o         = ack_q;
    assign timer_a_output_o = lvl_a_q;
    assign timer_b_output_o = out_b_q;
    assign timer_a_event_o  = irq_a_q;
    assign timer_b_event_o  = irq_b_q;
endmodule : dct_timer

// ===== dct_timer_props.sv
// concurrent checks on the ports of the dual timer block
`timescale 1ns/1ps
module dct_timer_props (
    // clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // register bus
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    // timer outputs and events
    input  wire logic        timer_a_output_o,
    input  wire logic        timer_b_output_o,
    input  wire logic        timer_a_event_o,
    input  wire logic        timer_b_event_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // a fresh request, and the single-cycle answer it must get
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    endsequence
    sequence s_ack;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_ack_one_shot: assert property (s_req |=> s_ack)
        else $error("ack missing or longer than one cycle");
    a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    a_ack_in_cycle: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
        else $error("ack outside a bus cycle");
    // read data only moves after a read was taken
    a_rdata_holds: assert property (!(wb_cyc_i && wb_stb_i && !wb_we_i)
        |=> $stable(wb_dat_o)) else $error("read data moved without a read");
    a_rdata_upper_zero: assert property (wb_dat_o[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    a_idle_levels_high: assert property ($past(rst_i) |->
        timer_a_output_o && timer_b_output_o)
        else $error("idle output level wrong after reset");
    a_events_quiet: assert property ($past(rst_i) |->
        !timer_a_event_o && !timer_b_event_o)
        else $error("event right after reset");
    a_event_a_pulse: assert property (timer_a_event_o |=> !timer_a_event_o)
        else $error("timer a event longer than one cycle");
    a_event_b_pulse: assert property (timer_b_event_o |=> !timer_b_event_o)
        else $error("timer b event longer than one cycle");
endmodule : dct_timer_props

// ===== dct_carrier_src.sv
// carrier source: square wave on the demodulator pin while run is high
`timescale 1ns/1ps
module dct_carrier_src #(
    parameter int HALF = 20
) (
    // clock and control
    input  wire logic clk_i,
    input  wire logic run_i,
    // carrier pin
    output logic      pin_o
);
    logic [7:0] cnt_q;

    // a source holds its line low when idle, so no stray edge appears
    always_ff @(posedge clk_i) begin
        if (!run_i) begin
            cnt_q <= 8'h00;
            pin_o <= 1'b0;
        end else if (cnt_q == 8'(HALF - 1)) begin
            cnt_q <= 8'h00;
            pin_o <= ~pin_o;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule : dct_carrier_src

// ===== dct_timer_tb.sv
// self-checking bench for the dual carrier timer block
`timescale 1ns/1ps
module dct_timer_tb;
    import dct_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [5:0]  wb_adr = 6'h00;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, out_a, out_b, ev_a, ev_b, pin_a;
    logic        run = 1'b0;
    logic [7:0]  q;
    logic [7:0]  fsh [3] = '{8'h08, 8'h0c, 8'h00};
    logic [2:0]  fexp = 3'b110;
    int          n, n_errors = 0, compares = 0, cycles = 0;

    always #20 clk_i = ~clk_i;

    dct_carrier_src #(.HALF(20)) dct_carrier_src_i (.clk_i(clk_i),
        .run_i(run), .pin_o(pin_a));
    dct_timer dct_timer_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(4'h1), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .demod_input_pin_a_i(pin_a), .demod_input_pin_b_i(1'b0),
        .timer_a_output_o(out_a), .timer_b_output_o(out_b),
        .timer_a_event_o(ev_a), .timer_b_event_o(ev_b));

    task automatic end_of_test();
        if (n_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            n_errors++;
        end
    endtask : chk

    // one classic cycle: held until the edge that sees ack, then released
    task automatic xfer(input logic [3:0] idx, input logic we,
                        input logic [7:0] d);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= {idx, 2'h0};
        wb_dat <= {24'h0, d};
        // ack is looked at on rising edges only; the bench timeout ends a hang
        do begin
            @(posedge clk_i);
        end while (!wb_ack_o);
        q = wb_dat_o[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : xfer

    // cycles until the next event pulse of one timer, capped
    task automatic wait_ev(input logic which, output int cnt);
        cnt = 0;
        do begin
            @(negedge clk_i);
            cnt++;
        end while (!(which ? ev_b : ev_a) && cnt < 600);
    endtask : wait_ev

    task automatic period(input logic which, output int cnt);
        wait_ev(which, cnt);
        wait_ev(which, cnt);
    endtask : period

    // a hang is cut short well above the expected run length
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            end_of_test();
        end
    end

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values across the map, unmapped places read zero
        for (int i = 0; i < 16; i++) begin
            xfer(4'(i), 1'b0, 8'h00);
            chk({8'h0, q}, (i >= 3 && i <= 6) ? 16'h00ff : 16'h0);
        end
        chk({14'h0, out_a, out_b}, 16'h0003);
        // timer_a single pass: level switch, stop at zero, toggle, flag
        xfer(IDX_RLD_AL, 1'b1, 8'h10);
        xfer(IDX_CTRL_A, 1'b1, 8'hc2);
        repeat (3) @(negedge clk_i);
        chk({15'h0, out_a}, 16'h0000);
        wait_ev(1'b0, n);
        repeat (2) @(negedge clk_i);
        chk({15'h0, out_a}, 16'h0001);
        // stop and clear as two writes; a written zero leaves the flag
        xfer(IDX_CTRL_A, 1'b1, 8'h00);
        xfer(IDX_CTRL_A, 1'b0, 8'h00);
        chk({8'h0, q}, 16'h0020);
        xfer(IDX_CTRL_A, 1'b1, 8'h20);
        xfer(IDX_CTRL_A, 1'b0, 8'h00);
        chk({8'h0, q}, 16'h0000);
        // timer_b output forced low, high, then back to idle level
        for (int i = 0; i < 3; i++) begin
            xfer(IDX_CTRL_SH, 1'b1, fsh[i]);
            repeat (4) @(negedge clk_i);
            chk({15'h0, out_b}, {15'h0, fexp[i]});
        end
        // modulo-N periods: two phases on a, divider and byte pair on b
        xfer(IDX_RLD_AL, 1'b1, 8'h05);
        xfer(IDX_RLD_AH, 1'b1, 8'h03);
        xfer(IDX_CTRL_A, 1'b1, 8'h82);
        period(1'b0, n);
        chk(16'(n), 16'd8);
        xfer(IDX_CTRL_A, 1'b1, 8'h00);
        xfer(IDX_CTRL_A, 1'b1, 8'h20);
        xfer(IDX_RLD_BL, 1'b1, 8'h06);
        xfer(IDX_RLD_BH, 1'b1, 8'h00);
        xfer(IDX_CTRL_B, 1'b1, 8'h8a);
        period(1'b1, n);
        chk(16'(n), 16'd12);
        xfer(IDX_CTRL_B, 1'b1, 8'h00);
        xfer(IDX_RLD_BL, 1'b1, 8'h02);
        xfer(IDX_RLD_BH, 1'b1, 8'h01);
        xfer(IDX_CTRL_B, 1'b1, 8'h82);
        period(1'b1, n);
        chk(16'(n), 16'd258);
        xfer(IDX_CTRL_B, 1'b1, 8'h00);
        xfer(IDX_CTRL_B, 1'b1, 8'h20);
        // ping-pong: both single pass, hardware hands the enable over
        xfer(IDX_CTRL_A, 1'b1, 8'h42);
        xfer(IDX_CTRL_B, 1'b1, 8'h42);
        xfer(IDX_CTRL_SH, 1'b1, 8'h04);
        xfer(IDX_CTRL_A, 1'b1, 8'hc2);
        wait_ev(1'b0, n);
        wait_ev(1'b1, n);
        chk({15'h0, n > 250 && n < 300}, 16'h0001);
        wait_ev(1'b0, n);
        chk({15'h0, n < 30}, 16'h0001);
        xfer(IDX_CTRL_SH, 1'b1, 8'h00);
        wait_ev(1'b1, n);
        wait_ev(1'b0, n);
        chk(16'(n), 16'd600);
        xfer(IDX_CTRL_A, 1'b1, 8'h20);
        xfer(IDX_CTRL_B, 1'b1, 8'h20);
        // demodulation of rising edges on the first pin
        xfer(IDX_RLD_AL, 1'b1, 8'hff);
        xfer(IDX_RLD_AH, 1'b1, 8'hff);
        xfer(IDX_CTRL_SH, 1'b1, 8'h90);
        xfer(IDX_CTRL_A, 1'b1, 8'h84);
        xfer(IDX_RLD_BL, 1'b1, 8'hff);
        xfer(IDX_RLD_BH, 1'b1, 8'hff);
        xfer(IDX_CTRL_B, 1'b1, 8'h84);
        run <= 1'b1;
        period(1'b0, n);
        chk(16'(n), 16'd40);
        xfer(IDX_CAP_AR, 1'b0, 8'h00);
        chk({15'h0, q >= 8'h26 && q <= 8'h29}, 16'h0001);
        // timer_b measured the same edge spacing as timer_a
        xfer(IDX_CAP_BL, 1'b0, 8'h00);
        chk({15'h0, q >= 8'h26 && q <= 8'h29}, 16'h0001);
        xfer(IDX_CAP_BH, 1'b0, 8'h00);
        chk({8'h0, q}, 16'h0000);
        xfer(IDX_CTRL_SH, 1'b0, 8'h00);
        chk({8'h0, q}, 16'h0092);
        // armed timer_b captures once, then lets two edges pass
        xfer(IDX_CTRL_B, 1'b1, 8'hc4);
        wait_ev(1'b1, n);
        chk({15'h0, n < 60}, 16'h0001);
        repeat (100) @(negedge clk_i);
        // quiet second pin selected, flag cleared by a written one
        xfer(IDX_CTRL_SH, 1'b1, 8'hd2);
        repeat (100) @(negedge clk_i);
        xfer(IDX_CTRL_SH, 1'b0, 8'h00);
        chk({8'h0, q}, 16'h00d0);
        // timer_a time-out captures timer_b, which never reloaded since its one
        // armed edge capture, so more than 256 counts have gone by
        wait_ev(1'b1, n);
        chk({15'h0, n < 300}, 16'h0001);
        xfer(IDX_CAP_BH, 1'b0, 8'h00);
        chk({8'h0, q}, 16'h0001);
        end_of_test();
    end
endmodule : dct_timer_tb

bind dct_timer dct_timer_props dct_timer_props_i (.clk_i(clk_i),
    .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .timer_a_output_o(timer_a_output_o),
    .timer_b_output_o(timer_b_output_o),
    .timer_a_event_o(timer_a_event_o), .timer_b_event_o(timer_b_event_o));
